// ---- hw/owd_pkg.sv ----
// Shared constants, state codes and carriers of the one-wire debug port physical layer
package owd_pkg;
  localparam int DATA_BITS = 8;
  localparam int FRAME_BITS = 12;
  localparam int BREAK_BITS = 12;
  localparam int BAUD_W = 16;
  localparam int ACC_W = 17;
  localparam int LOW_W = 20;
  localparam int MEAS_MAX = 65535;
  localparam int SYNCH_FALLS = 4;
  localparam logic [3:0] IDX_START = 4'h0;
  localparam logic [3:0] IDX_LAST_DATA = 4'h8;
  localparam logic [3:0] IDX_PARITY = 4'h9;
  localparam logic [3:0] IDX_STOP1 = 4'hA;
  localparam logic [3:0] IDX_STOP2 = 4'hB;
  localparam logic [ACC_W-1:0] ACC_STEP = 17'h00008;
  localparam logic [LOW_W-1:0] LOW_STEP = 20'h00008;
  localparam logic [LOW_W-1:0] BREAK_LIM_COLD = 20'(BREAK_BITS * MEAS_MAX);
  localparam logic [BAUD_W-1:0] BAUD_MIN = 16'h0010;
  localparam logic [BAUD_W-1:0] BAUD_MAXV = 16'hFFFF;
  localparam logic [7:0] SYNCH_BYTE = 8'h55;
  localparam logic [7:0] ACK_BYTE = 8'h40;
  localparam logic [1:0] CLKSEL_32M = 2'h0;
  localparam logic [1:0] CLKSEL_16M = 2'h1;
  localparam logic [1:0] CLKSEL_8M = 2'h2;
  localparam logic [1:0] CLKSEL_4M = 2'h3;
  localparam logic [1:0] CLKSEL_RST = CLKSEL_4M;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_MEAS = 2'b01,
    RX_BITS = 2'b10
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_GUARD = 2'b01,
    TX_BITS = 2'b10
  } tx_state_t;

  typedef struct packed {
    logic parity;
    logic frame;
    logic contention;
    logic synch;
  } err_flags_t;
endpackage : owd_pkg

// ---- hw/resp_fifo.sv ----
// Response byte FIFO in flip-flops with valid and ready on both sides
`timescale 1ns/1ps
module resp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] wr_nxt;
  logic [AW:0] rd_r;
  logic [AW:0] rd_nxt;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = (wr_r == rd_r);
  assign full = (wr_r[AW-1:0] == rd_r[AW-1:0]) && (wr_r[AW] != rd_r[AW]);
  assign o_ready = ~full;
  assign o_valid = ~empty;
  assign o_data = mem_r[rd_r[AW-1:0]];
  assign push = i_valid & ~full;
  assign pop = i_ready & ~empty;

  always_comb begin
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= i_data;
    end
  end
endmodule : resp_fifo

// ---- hw/one_wire_debug_uart_phy.sv ----
// Physical layer of the one-wire debug port: auto-baud UART receiver, responder, line reset
//
// What this block does
// - Frames: low start, eight data bits, even parity, two high stops.
// - Wrong parity or low stop bit raises an error flag.
// - Parity-check-off input skips the parity check of data frames; a synch frame's parity is still checked.
// - Idle is the line high for twelve or more bit times.
// - Line low twelve bit times is a line reset, returning default state.
// - A synch character is expected per new instruction and after line reset.
// - Acknowledge frame sent once a store gains bus access; debugger then waits.
// - Measured baud is kept and used for receive and transmit.
// - No writable baud; recovery uses only the synch sample count.
// - Clock select 0..3 is 32/16/8/4 MHz, default 3 after reset, enable.
// - Fractional bit timing; tolerance +4.76/-3.61 percent.
// - Line reset mid-reception is frame error, mid-transmission contention; both abort.
// - A line reset restores the clock select to 4 MHz.
// - Baud measurement counter is sixteen bits, up to 65535 cycles.
// - Synch is byte 0x55 in normal framing; its edges are counted.
// - When disabled, a valid synch character enables the port.
// - Under instruction repeat, synch only before the first instruction.
// - No frames before the port is enabled.
// - After an error, all traffic except a line reset is ignored.
// - Guard idle bits at the current baud precede the first response.
`timescale 1ns/1ps
module one_wire_debug_uart_phy
  import owd_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int GUARD_W = 3
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_line,
  output logic o_line_out,
  output logic o_line_oe,
  input wire logic i_parity_check_off,
  input wire logic [GUARD_W-1:0] i_guard_idle_count,
  input wire logic i_clksel_wr,
  input wire logic [1:0] i_clksel_val,
  output logic [1:0] o_link_clock_select,
  input wire logic i_disable,
  input wire logic i_synch_expect,
  input wire logic i_ack_req,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_enabled,
  output logic o_error,
  output err_flags_t o_err_flags,
  output logic o_break_det,
  output logic o_synch_ok
);
  rx_state_t rx_state_r, rx_state_nxt;
  logic [ACC_W-1:0] rx_acc_r, rx_acc_nxt;
  logic [3:0] rx_idx_r, rx_idx_nxt;
  logic [7:0] rx_shift_r, rx_shift_nxt;
  logic rx_pbad_r, rx_pbad_nxt;
  logic syn_r, syn_nxt;
  logic [BAUD_W-1:0] meas_r, meas_nxt;
  logic [2:0] falls_r, falls_nxt;
  logic [BAUD_W-1:0] baud_r, baud_nxt;
  logic baud_ok_r, baud_ok_nxt;
  logic [LOW_W-1:0] low_r, low_nxt;
  logic brk_seen_r, brk_seen_nxt;
  logic line_q_r, line_q_nxt;
  logic need_syn_r, need_syn_nxt;
  logic en_r, en_nxt;
  logic [1:0] sel_r, sel_nxt;
  err_flags_t flags_r, flags_nxt;
  logic dir_rx_r, dir_rx_nxt;
  logic rxv_r, rxv_nxt;
  logic [7:0] rxd_r, rxd_nxt;
  logic brk_r, brk_nxt;
  logic synok_r, synok_nxt;
  logic [ACC_W-1:0] rx_sum;
  logic [LOW_W-1:0] brk_lim;
  logic brk;
  logic fall;
  logic tick;

  tx_state_t tx_state_r, tx_state_nxt;
  logic [ACC_W-1:0] tx_acc_r, tx_acc_nxt;
  logic [3:0] tx_idx_r, tx_idx_nxt;
  logic [FRAME_BITS-1:0] frm_r, frm_nxt;
  logic [GUARD_W-1:0] grd_r, grd_nxt;
  logic ack_r, ack_nxt;
  logic oe_r, oe_nxt;
  logic out_r, out_nxt;
  logic [ACC_W-1:0] tx_sum;
  logic [ACC_W-1:0] half;
  logic tx_tick;
  logic tx_mid;
  logic tx_cont;
  logic tx_start;
  logic fifo_v;
  logic fifo_pop;
  logic [7:0] fifo_d;
  logic [7:0] tx_byte;

  function automatic logic [FRAME_BITS-1:0] build_frame(input logic [7:0] d);
    build_frame = {2'b11, ^d, d, 1'b0};
  endfunction : build_frame

  assign half = {2'b00, baud_r[BAUD_W-1:1]};
  assign fall = line_q_r & ~i_line & (tx_state_r == TX_IDLE);
  assign rx_sum = rx_acc_r + ACC_STEP;
  assign tick = (rx_sum >= {1'b0, baud_r});
  assign brk_lim = baud_ok_r ? ({4'h0, baud_r} << 3) + ({4'h0, baud_r} << 2) : BREAK_LIM_COLD;
  assign brk = en_r && (low_r >= brk_lim) && !brk_seen_r && rx_state_r == RX_IDLE
               && tx_state_r == TX_IDLE;

  always_comb begin
    rx_state_nxt = rx_state_r;
    rx_acc_nxt = rx_sum;
    rx_idx_nxt = rx_idx_r;
    rx_shift_nxt = rx_shift_r;
    rx_pbad_nxt = rx_pbad_r;
    syn_nxt = syn_r;
    meas_nxt = meas_r;
    falls_nxt = falls_r;
    baud_nxt = baud_r;
    baud_ok_nxt = baud_ok_r;
    line_q_nxt = i_line;
    low_nxt = i_line ? '0 : ((low_r >= brk_lim) ? low_r : low_r + LOW_STEP);
    brk_seen_nxt = (low_r >= brk_lim) && !i_line;
    need_syn_nxt = need_syn_r | i_synch_expect;
    en_nxt = en_r;
    sel_nxt = i_clksel_wr ? i_clksel_val : sel_r;
    flags_nxt = flags_r;
    dir_rx_nxt = dir_rx_r & ~tx_start;
    rxv_nxt = 1'b0;
    rxd_nxt = rxd_r;
    brk_nxt = brk;
    synok_nxt = 1'b0;
    flags_nxt.contention = flags_r.contention | tx_cont;
    unique case (rx_state_r)
      RX_IDLE: begin
        rx_acc_nxt = '0;
        if (fall && ~(|flags_r) && need_syn_r) begin
          rx_state_nxt = RX_MEAS;
          meas_nxt = '0;
          falls_nxt = '0;
        end else if (fall && ~(|flags_r) && en_r) begin
          rx_state_nxt = RX_BITS;
          rx_acc_nxt = half;
          rx_idx_nxt = IDX_START;
          syn_nxt = 1'b0;
        end
      end
      RX_MEAS: begin
        meas_nxt = meas_r + 1'b1;
        if (fall) begin
          falls_nxt = falls_r + 1'b1;
        end
        if (meas_r == BAUD_MAXV) begin
          rx_state_nxt = RX_IDLE;
          flags_nxt.synch = flags_r.synch | en_r;
        end else if (fall && falls_r == 3'(SYNCH_FALLS - 1)) begin
          if (meas_nxt < BAUD_MIN) begin
            rx_state_nxt = RX_IDLE;
            flags_nxt.synch = flags_r.synch | en_r;
          end else begin
            baud_nxt = meas_nxt;
            baud_ok_nxt = 1'b1;
            rx_state_nxt = RX_BITS;
            rx_acc_nxt = {2'b00, meas_nxt[BAUD_W-1:1]};
            rx_idx_nxt = IDX_LAST_DATA;
            rx_shift_nxt = {SYNCH_BYTE[DATA_BITS-2:0], 1'b0};
            syn_nxt = 1'b1;
          end
        end
      end
      RX_BITS: begin
        if (tick) begin
          rx_acc_nxt = rx_sum - {1'b0, baud_r};
          rx_idx_nxt = rx_idx_r + 1'b1;
          if (rx_idx_r == IDX_START) begin
            if (i_line) begin
              rx_state_nxt = RX_IDLE;
            end
          end else if (rx_idx_r <= IDX_LAST_DATA) begin
            rx_shift_nxt = {i_line, rx_shift_r[7:1]};
          end else if (rx_idx_r == IDX_PARITY) begin
            rx_pbad_nxt = (i_line != ^rx_shift_r);
          end else if (rx_idx_r == IDX_STOP1) begin
            if (!i_line) begin
              rx_state_nxt = RX_IDLE;
              flags_nxt.synch = flags_r.synch | (syn_r & en_r);
              flags_nxt.frame = flags_r.frame | (~syn_r);
            end
          end else begin
            rx_state_nxt = RX_IDLE;
            dir_rx_nxt = 1'b1;
            if (syn_r) begin
              if (!i_line || rx_pbad_r) begin
                flags_nxt.synch = flags_r.synch | en_r;
              end else begin
                en_nxt = 1'b1;
                need_syn_nxt = i_synch_expect;
                synok_nxt = 1'b1;
                if (!en_r) begin
                  sel_nxt = CLKSEL_RST;
                end
              end
            end else if (!i_line) begin
              flags_nxt.frame = 1'b1;
            end else if (rx_pbad_r && !i_parity_check_off) begin
              flags_nxt.parity = 1'b1;
            end else begin
              rxv_nxt = 1'b1;
              rxd_nxt = rx_shift_r;
            end
          end
        end
      end
      default: begin
        rx_state_nxt = RX_IDLE;
      end
    endcase
    if (brk) begin
      flags_nxt = '0;
      need_syn_nxt = 1'b1;
      sel_nxt = CLKSEL_RST;
    end
    if (i_disable) begin
      en_nxt = 1'b0;
      need_syn_nxt = 1'b1;
      rx_state_nxt = RX_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_state_r <= RX_IDLE;
      rx_acc_r <= '0;
      rx_idx_r <= '0;
      rx_shift_r <= '0;
      rx_pbad_r <= 1'b0;
      syn_r <= 1'b0;
      meas_r <= '0;
      falls_r <= '0;
      baud_r <= BAUD_MAXV;
      baud_ok_r <= 1'b0;
      low_r <= '0;
      brk_seen_r <= 1'b0;
      line_q_r <= 1'b1;
      need_syn_r <= 1'b1;
      en_r <= 1'b0;
      sel_r <= CLKSEL_RST;
      flags_r <= '0;
      dir_rx_r <= 1'b0;
      rxv_r <= 1'b0;
      rxd_r <= '0;
      brk_r <= 1'b0;
      synok_r <= 1'b0;
    end else begin
      rx_state_r <= rx_state_nxt;
      rx_acc_r <= rx_acc_nxt;
      rx_idx_r <= rx_idx_nxt;
      rx_shift_r <= rx_shift_nxt;
      rx_pbad_r <= rx_pbad_nxt;
      syn_r <= syn_nxt;
      meas_r <= meas_nxt;
      falls_r <= falls_nxt;
      baud_r <= baud_nxt;
      baud_ok_r <= baud_ok_nxt;
      low_r <= low_nxt;
      brk_seen_r <= brk_seen_nxt;
      line_q_r <= line_q_nxt;
      need_syn_r <= need_syn_nxt;
      en_r <= en_nxt;
      sel_r <= sel_nxt;
      flags_r <= flags_nxt;
      dir_rx_r <= dir_rx_nxt;
      rxv_r <= rxv_nxt;
      rxd_r <= rxd_nxt;
      brk_r <= brk_nxt;
      synok_r <= synok_nxt;
    end
  end

  assign tx_sum = tx_acc_r + ACC_STEP;
  assign tx_tick = (tx_sum >= {1'b0, baud_r});
  assign tx_mid = (tx_acc_r < half) && (tx_sum >= half);
  assign tx_cont = (tx_state_r == TX_BITS) && tx_mid && oe_r && out_r && !i_line;
  assign tx_byte = ack_r ? ACK_BYTE : fifo_d;

  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_acc_nxt = tx_tick ? tx_sum - {1'b0, baud_r} : tx_sum;
    tx_idx_nxt = tx_idx_r;
    frm_nxt = frm_r;
    grd_nxt = grd_r;
    ack_nxt = ack_r | i_ack_req;
    fifo_pop = 1'b0;
    tx_start = 1'b0;
    unique case (tx_state_r)
      TX_IDLE: begin
        tx_acc_nxt = '0;
        if (en_r && ~(|flags_r) && !brk && rx_state_r == RX_IDLE && (ack_r || fifo_v)) begin
          frm_nxt = build_frame(tx_byte);
          fifo_pop = ~ack_r;
          ack_nxt = i_ack_req;
          tx_idx_nxt = IDX_START;
          grd_nxt = i_guard_idle_count;
          if (dir_rx_r && i_guard_idle_count != '0) begin
            tx_state_nxt = TX_GUARD;
          end else begin
            tx_state_nxt = TX_BITS;
            tx_start = 1'b1;
          end
        end
      end
      TX_GUARD: begin
        if (tx_tick) begin
          grd_nxt = grd_r - 1'b1;
          if (grd_r == GUARD_W'(1)) begin
            tx_state_nxt = TX_BITS;
            tx_start = 1'b1;
          end
        end
      end
      TX_BITS: begin
        if (tx_tick) begin
          frm_nxt = {1'b1, frm_r[FRAME_BITS-1:1]};
          tx_idx_nxt = tx_idx_r + 1'b1;
          if (tx_idx_r == IDX_STOP2) begin
            tx_state_nxt = TX_IDLE;
          end
        end
      end
      default: begin
        tx_state_nxt = TX_IDLE;
      end
    endcase
    if (tx_cont || brk || !en_r || (|flags_r)) begin
      tx_state_nxt = TX_IDLE;
      tx_start = 1'b0;
    end
    if (brk) begin
      ack_nxt = i_ack_req;
    end
    oe_nxt = (tx_state_nxt == TX_BITS);
    out_nxt = frm_nxt[0];
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_state_r <= TX_IDLE;
      tx_acc_r <= '0;
      tx_idx_r <= '0;
      frm_r <= '1;
      grd_r <= '0;
      ack_r <= 1'b0;
      oe_r <= 1'b0;
      out_r <= 1'b1;
    end else begin
      tx_state_r <= tx_state_nxt;
      tx_acc_r <= tx_acc_nxt;
      tx_idx_r <= tx_idx_nxt;
      frm_r <= frm_nxt;
      grd_r <= grd_nxt;
      ack_r <= ack_nxt;
      oe_r <= oe_nxt;
      out_r <= out_nxt;
    end
  end

  resp_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_resp_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(i_tx_valid),
    .o_ready(o_tx_ready),
    .i_data(i_tx_data),
    .o_valid(fifo_v),
    .i_ready(fifo_pop),
    .o_data(fifo_d)
  );

  assign o_line_out = out_r;
  assign o_line_oe = oe_r;
  assign o_link_clock_select = sel_r;
  assign o_enabled = en_r;
  assign o_error = |flags_r;
  assign o_err_flags = flags_r;
  assign o_rx_valid = rxv_r;
  assign o_rx_data = rxd_r;
  assign o_break_det = brk_r;
  assign o_synch_ok = synok_r;
endmodule : one_wire_debug_uart_phy

// ---- testbench/owd_phy_monitor.sv ----
// Assertion checker for the one-wire debug port physical layer
`timescale 1ns/1ps
module owd_phy_monitor
  import owd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_line,
  input wire logic o_line_out,
  input wire logic o_line_oe,
  input wire logic [1:0] o_link_clock_select,
  input wire logic o_rx_valid,
  input wire logic o_enabled,
  input wire logic o_error,
  input wire logic o_break_det,
  input wire logic o_synch_ok
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_tx_begin;
    !o_line_oe ##1 o_line_oe;
  endsequence
  sequence s_tx_end;
    o_line_oe ##1 (!o_line_oe && !o_error);
  endsequence
  a_reset_defaults: assert property ($fell(i_rst) |->
    o_link_clock_select == CLKSEL_RST && !o_line_oe && !o_enabled && !o_error)
    else $error("defaults wrong after reset");
  a_break_clksel: assert property (o_break_det |=>
    o_link_clock_select == CLKSEL_4M && !o_error) else $error("break did not restore");
  a_break_single: assert property (o_break_det |->
    !$past(i_line) ##1 !o_break_det [*2]) else $error("break pulse wrong");
  a_error_blocks_rx: assert property (o_error |->
    !o_rx_valid && !o_synch_ok) else $error("byte taken in error state");
  a_rx_when_enabled: assert property (o_rx_valid |-> o_enabled)
    else $error("byte taken while disabled");
  a_synch_enables: assert property (o_synch_ok |-> o_enabled && $past(i_line))
    else $error("synch did not enable");
  a_tx_start_low: assert property (s_tx_begin |->
    !o_line_out && o_enabled && !$past(o_error)) else $error("bad response start");
  a_tx_stop_high: assert property (s_tx_end |-> $past(o_line_out))
    else $error("response ended without stop");
  a_flags_sticky: assert property ($fell(o_error) |->
    o_break_det || $past(o_break_det)) else $error("error cleared without break");
endmodule : owd_phy_monitor
bind one_wire_debug_uart_phy owd_phy_monitor u_mon (.*);

// ---- testbench/owd_host_model.sv ----
// Debugger model that pulls the shared debug line low or leaves it to the pull-up
`timescale 1ns/1ps
module owd_host_model (
  input wire logic i_clk,
  output logic o_pull_low
);
  initial o_pull_low = 1'b0;
  // One frame at n clocks per bit; high bits come from the pull-up
  task automatic send(input logic [7:0] d, input int n, input logic pbad, input logic sbad);
    logic [11:0] f;
    f = {1'b1, ~sbad, ^d ^ pbad, d, 1'b0};
    for (int i = 0; i < 12; i++) begin
      @(negedge i_clk);
      o_pull_low = ~f[i];
      repeat (n - 1) @(negedge i_clk);
    end
  endtask : send
  // Line reset: hold low, then release
  task automatic brk(input int cyc);
    @(negedge i_clk);
    o_pull_low = 1'b1;
    repeat (cyc) @(negedge i_clk);
    o_pull_low = 1'b0;
  endtask : brk
endmodule : owd_host_model

// ---- testbench/one_wire_debug_uart_phy_tb_top.sv ----
// Self-checking bench for the one-wire debug port physical layer
`timescale 1ns/1ps
module one_wire_debug_uart_phy_tb_top;
  import owd_pkg::*;
  localparam int N = 4;
  typedef struct packed {
    logic [7:0] d;
    logic pb;
    logic sb;
    logic po;
    logic ev;
    err_flags_t ef;
  } row_t;
  // Byte, bad parity, bad stop, parity check off, byte expected, flags expected
  row_t rows [6] = '{16'hA510, 16'h0010, 16'hFF10, 16'h3CB0, 16'h3C88, 16'h8144};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic line, out, oe, poff, wr, dis, sx, ack, txv, txr, en, err, brk, sok, hlow, rxv;
  logic [1:0] selv, sel;
  logic [7:0] txd, rxd, got;
  err_flags_t flags, seen;
  int bad_count = 0;
  int checks = 0;
  int rx_n = 0;
  int brk_n = 0;
  int sok_n = 0;
  int k, c, n;
  always #12.5 clk = ~clk;
  assign line = ~hlow & ~(oe & ~out);
  owd_host_model host (.i_clk(clk), .o_pull_low(hlow));
  one_wire_debug_uart_phy dut (.i_clk(clk), .i_rst(rst), .i_line(line), .o_line_out(out),
    .o_line_oe(oe), .i_parity_check_off(poff), .i_guard_idle_count(3'h3),
    .i_clksel_wr(wr), .i_clksel_val(selv), .o_link_clock_select(sel), .i_disable(dis),
    .i_synch_expect(sx), .i_ack_req(ack), .i_tx_valid(txv), .i_tx_data(txd),
    .o_tx_ready(txr), .o_rx_valid(rxv), .o_rx_data(rxd), .o_enabled(en), .o_error(err),
    .o_err_flags(flags), .o_break_det(brk), .o_synch_ok(sok));
  always @(posedge clk) begin
    rx_n += int'(rxv === 1'b1);
    brk_n += int'(brk === 1'b1);
    sok_n += int'(sok === 1'b1);
    seen = seen | flags;
  end
  task automatic final_report();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("Error %0t %s", $time, m);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task automatic synch(input int b);
    c = sok_n;
    host.send(SYNCH_BYTE, b, 1'b0, 1'b0);
    repeat (4) @(negedge clk);
    chk(sok_n == c + 1 && en === 1'b1, "synch not taken");
  endtask : synch
  task automatic recover();
    c = brk_n;
    host.brk(30 * N);
    repeat (4) @(negedge clk);
    chk(brk_n == c + 1 && err === 1'b0 && sel === CLKSEL_4M, "line reset");
    synch(N);
  endtask : recover
  // Decodes one response frame; the first waits out the guard, later ones one idle cycle
  task automatic get_resp(input logic first, output logic [7:0] d);
    logic [11:0] f;
    k = 0;
    while (oe !== 1'b1 && k < (first ? 400 : 2)) begin
      @(negedge clk);
      k++;
    end
    if (oe !== 1'b1) begin
      bad_count++;
      final_report();
    end
    for (int b = 0; b < 12; b++) begin
      repeat (b == 0 ? N / 2 : N) @(negedge clk);
      f[b] = out;
      chk(oe === 1'b1, "line not driven in frame");
    end
    repeat (N - N / 2) @(negedge clk);
    d = f[8:1];
    chk(f[0] === 1'b0 && f[11:10] === 2'b11 && ^f[9:1] === 1'b0, "response framing");
  endtask : get_resp
  initial begin
    {poff, wr, dis, sx, ack, txv} = '0;
    selv = 2'h0;
    txd = 8'h00;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    seen = '0;
    chk(sel === CLKSEL_RST && oe === 1'b0 && en === 1'b0 && err === 1'b0, "reset");
    synch(N);
    for (int i = 3; i >= 0; i--) begin
      selv = 2'(i);
      pulse(wr);
      chk(sel === 2'(i), "clock select");
    end
    foreach (rows[i]) begin
      poff = rows[i].po;
      seen = '0;
      c = rx_n;
      host.send(rows[i].d, N, rows[i].pb, rows[i].sb);
      repeat (4) @(negedge clk);
      chk(rx_n == c + int'(rows[i].ev) && seen === rows[i].ef, "frame outcome");
      if (rows[i].ev) begin
        chk(rxd === rows[i].d, "data");
      end else begin
        recover();
      end
    end
    pulse(sx);
    synch(6);
    c = rx_n;
    host.send(8'h96, 6, 1'b0, 1'b0);
    repeat (6) @(negedge clk);
    chk(rx_n == c + 1 && rxd === 8'h96, "new baud");
    pulse(sx);
    seen = '0;
    host.send(SYNCH_BYTE, 1, 1'b0, 1'b0);
    repeat (4) @(negedge clk);
    chk(seen.synch === 1'b1, "short synch");
    recover();
    host.send(8'hC3, N, 1'b0, 1'b0);
    pulse(ack);
    get_resp(1'b1, got);
    chk(got === ACK_BYTE && k > 2 * N, "ack after guard");
    pulse(dis);
    n = 0;
    for (int i = 0; i < 10; i++) begin
      txd = 8'h10 + 8'(i);
      txv = 1'b1;
      n += int'(txr === 1'b1);
      @(negedge clk);
    end
    txv = 1'b0;
    chk(n == 8 && txr === 1'b0 && en === 1'b0 && oe === 1'b0, "fifo fill");
    host.send(SYNCH_BYTE, N, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      get_resp(i == 0, got);
      chk(got === 8'h10 + 8'(i), "fifo order");
    end
    chk(oe === 1'b0 && en === 1'b1, "released after burst");
    pulse(ack);
    repeat (2 * N) @(negedge clk);
    chk(oe === 1'b1, "ack started");
    seen = '0;
    recover();
    chk(seen.contention === 1'b1, "contention");
    final_report();
  end
endmodule : one_wire_debug_uart_phy_tb_top
